//--- rtl/phs_port.sv
// Pulsed two-wire handshake engine for a strobed parallel port, APB controlled
// Behaviour
// RL1: With edge latching on in long-pulse input, the peripheral holds data from before the request edge to 10 ns after it.
// RL2: With edge latching off in long-pulse input, the peripheral holds data until the acknowledge, no hold after it.
// RL3: Each long-pulse acknowledge stays high at least 125 ns plus the settling delay.
// RL4: In long-pulse input the acknowledge ends no sooner than 150 ns after the request went inactive.
// RL5: With edge latching on in long-pulse output, the next word appears 0 to 50 ns after the request goes inactive.
// RL6: With edge latching off in long-pulse output, the word is valid at least 25 ns before the acknowledge rises.
// RL7: With edge latching off in long-pulse output, the word changes only at or after the request.
// RL8: In trailing-edge mode both sides send pulses whose trailing edge means ready for a transfer.
// RL9: In trailing-edge input an acknowledge pulse of programmable width goes out whenever a word can be taken.
// RL10: In trailing-edge input the peripheral strobes a word in by ending its request pulse after the acknowledge ends.
// RL11: In trailing-edge input a further acknowledge goes out only once room for another word exists.
// RL12: The settling delay widens the trailing-edge acknowledge, lengthening data setup on output.
// RL13: In trailing-edge output the word is driven first and only then the acknowledge marks it new.
// RL14: In trailing-edge output the peripheral takes the word on either acknowledge edge or before its request ends.
// RL15: In trailing-edge output the request trailing edge ends the acknowledge and asks for the next word.
// RL16: In long-pulse mode the settling delay lengthens the acknowledge instead of delaying its start.
// RL17: The settling delay and all least pulse widths are counted in whole cycles of the clock.
module phs_port import phs_pkg::*; #(
    parameter int DW = DATA_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reqIn,
    output logic ackOut,
    input wire logic [DW-1:0] dataIn,
    output logic [DW-1:0] dataOut,
    output logic dataOeN
);
    typedef struct packed {
        phs_state_e st;
        logic [CNT_W:0] cnt;
        logic [7:0] lowCnt;
        logic riseP;
        logic fallP;
        logic reqQ;
        logic ackQ;
        logic oeNQ;
        logic haveWord;
        logic [DW-1:0] dOutQ;
        logic [DW-1:0] capQ;
        logic en;
        logic dirOut;
        logic trail;
        logic latch;
        logic [CNT_W-1:0] settle;
        logic [CNT_W-1:0] ackW;
        logic [31:0] xfers;
        logic [31:0] prdataQ;
        logic preadyQ;
        logic slverrQ;
        logic [CNT_W:0] ackLen;
        logic [7:0] dataAge;
    } phs_regs_s;

    phs_regs_s s, n;
    phs_stream_if #(.W(DW)) bufIf ();

    logic reqRise, reqFall, takeRise, takeFall, cntZero, access;
    logic [CNT_W:0] ackSum, ackLoad;
    logic [31:0] rdVal;
    logic rdErr, stall;

    phs_buf2 #(.W(DW), .DEPTH(BUF_DEPTH)) uBuf (
        .clk(clk),
        .rst(rst),
        .port(bufIf.store)
    );

    always_comb begin
        n = s;
        bufIf.wValid = 1'b0;
        bufIf.wData = dataIn;
        bufIf.rReady = 1'b0;
        takeRise = 1'b0;
        takeFall = 1'b0;
        rdVal = 32'h00000000;
        rdErr = 1'b0;
        stall = 1'b0;
        reqRise = reqIn && !s.reqQ;
        reqFall = !reqIn && s.reqQ;
        cntZero = (s.cnt == '0);
        access = psel && penable;
        // Settling delay stretches the pulse, never its start
        ackSum = {1'b0, (s.trail ? s.ackW : CNT_W'(ACK_MIN_CYC))} + {1'b0, s.settle}; // RL16 RL17
        ackLoad = (ackSum == '0) ? '0 : ackSum - (CNT_W+1)'(1);
        n.reqQ = reqIn;
        n.lowCnt = reqIn ? 8'h00 : ((s.lowCnt == 8'hFF) ? s.lowCnt : s.lowCnt + 8'h01);
        n.oeNQ = !(s.en && s.dirOut);
        if (reqRise && s.latch) begin
            n.capQ = dataIn; // RL1
        end
        if (s.st == PHS_ACK || s.st == PHS_SETUP) begin
            if (!cntZero) begin
                n.cnt = s.cnt - (CNT_W+1)'(1);
            end
        end
        // Next word follows the request's inactive edge within one cycle
        if (s.en && !s.trail && s.dirOut && s.latch && reqFall) begin
            bufIf.rReady = 1'b1; // RL5
            n.haveWord = bufIf.rValid;
            if (bufIf.rValid) begin
                n.dOutQ = bufIf.rData;
            end
        end
        if (!s.en) begin
            n.st = PHS_IDLE;
            n.ackQ = 1'b0;
            n.haveWord = 1'b0;
            takeRise = 1'b1;
            takeFall = 1'b1;
        end else begin
            case (s.st)
                PHS_IDLE: begin
                    if (!s.trail && !s.dirOut) begin
                        if ((s.riseP || reqRise) && bufIf.wReady) begin
                            // Word taken with the request edge or with the rising acknowledge
                            bufIf.wValid = 1'b1; // RL1 RL2
                            bufIf.wData = (s.latch && !reqRise) ? s.capQ : dataIn;
                            takeRise = 1'b1;
                            n.st = PHS_ACK;
                            n.ackQ = 1'b1;
                            n.cnt = ackLoad; // RL3
                        end
                    end else if (!s.trail) begin
                        if (s.latch && !s.haveWord && bufIf.rValid && !reqFall) begin
                            bufIf.rReady = 1'b1;
                            n.dOutQ = bufIf.rData;
                            n.haveWord = 1'b1;
                        end else if ((s.riseP || reqRise) && s.latch && s.haveWord) begin
                            takeRise = 1'b1;
                            n.st = PHS_ACK;
                            n.ackQ = 1'b1;
                            n.cnt = ackLoad; // RL3
                        end else if ((s.riseP || reqRise) && !s.latch && bufIf.rValid) begin
                            // Update only once the request is seen
                            bufIf.rReady = 1'b1; // RL7
                            n.dOutQ = bufIf.rData;
                            n.haveWord = 1'b1;
                            takeRise = 1'b1;
                            n.st = PHS_SETUP;
                            n.cnt = (CNT_W+1)'(DOA_CYC - 1); // RL6
                        end
                    end else if (!s.dirOut) begin
                        takeFall = 1'b1;
                        takeRise = 1'b1;
                        if (bufIf.wReady) begin
                            n.st = PHS_ACK; // RL9 RL11
                            n.ackQ = 1'b1;
                            n.cnt = ackLoad; // RL12
                        end
                    end else begin
                        takeRise = 1'b1;
                        if (bufIf.rValid) begin
                            bufIf.rReady = 1'b1; // RL13
                            n.dOutQ = bufIf.rData;
                            n.haveWord = 1'b1;
                            n.st = PHS_SETUP;
                            n.cnt = (CNT_W+1)'(DOA_CYC - 1);
                        end
                    end
                end
                PHS_SETUP: begin
                    if (cntZero) begin
                        n.st = PHS_ACK;
                        n.ackQ = 1'b1;
                        n.cnt = ackLoad; // RL12 RL13
                        takeFall = 1'b1;
                    end
                end
                PHS_ACK: begin
                    if (!s.trail && !s.dirOut) begin
                        // Inactive request must have lasted long enough first
                        if (cntZero && !reqIn && s.lowCnt >= 8'(REQ_OFF_CYC - 1)) begin
                            n.ackQ = 1'b0; // RL4
                            n.st = PHS_IDLE;
                            n.xfers = s.xfers + 32'h00000001;
                        end
                    end else if (!s.trail) begin
                        if (cntZero) begin
                            n.ackQ = 1'b0; // RL3
                            n.st = PHS_IDLE;
                            n.xfers = s.xfers + 32'h00000001;
                        end
                    end else if (!s.dirOut) begin
                        if (cntZero) begin
                            // Trailing edge tells the peripheral room is free
                            n.ackQ = 1'b0; // RL8
                            n.st = PHS_WAIT;
                            takeFall = 1'b1;
                        end
                    end else if (cntZero && (s.fallP || reqFall)) begin
                        // Request trailing edge closes the pulse and asks for more
                        n.ackQ = 1'b0; // RL15
                        takeFall = 1'b1;
                        n.st = PHS_IDLE;
                        n.xfers = s.xfers + 32'h00000001;
                    end
                end
                PHS_WAIT: begin
                    if (reqFall) begin
                        // Room was checked before the pulse, so the push cannot stall
                        bufIf.wValid = 1'b1; // RL10
                        bufIf.wData = dataIn;
                        takeFall = 1'b1;
                        n.st = PHS_IDLE;
                        n.xfers = s.xfers + 32'h00000001;
                    end
                end
                default: begin
                    n.st = PHS_IDLE;
                end
            endcase
        end
        if (takeRise) begin
            n.riseP = 1'b0;
        end
        if (takeFall) begin
            n.fallP = 1'b0;
        end
        // Edges seen in a consuming cycle are kept only if not consumed there
        if (reqRise && !takeRise) begin
            n.riseP = 1'b1;
        end
        if (reqFall && !takeFall) begin
            n.fallP = 1'b1;
        end
        if (reqRise && !s.dirOut && !s.trail && !takeRise) begin
            n.riseP = 1'b1;
        end
        // Register bus
        if (paddr == OFS_CTRL) begin
            rdVal = {28'h0000000, s.latch, s.trail, s.dirOut, s.en};
        end else if (paddr == OFS_SETTLE) begin
            rdVal = {16'h0000, s.settle};
        end else if (paddr == OFS_ACKW) begin
            rdVal = {16'h0000, s.ackW};
        end else if (paddr == OFS_TXDATA) begin
            rdErr = pwrite ? !s.dirOut : 1'b0;
            stall = pwrite && s.dirOut && !bufIf.wReady;
        end else if (paddr == OFS_RXDATA) begin
            rdVal = 32'(bufIf.rData);
            rdErr = pwrite || s.dirOut || !bufIf.rValid;
        end else if (paddr == OFS_STATUS) begin
            rdVal[ST_RVALID] = bufIf.rValid;
            rdVal[ST_WREADY] = bufIf.wReady;
            rdVal[ST_STATE +: 2] = s.st;
            rdVal[ST_ACK] = s.ackQ;
            rdVal[ST_REQ] = s.reqQ;
            rdVal[ST_HAVE] = s.haveWord;
        end else if (paddr == OFS_COUNT) begin
            rdVal = s.xfers;
        end else begin
            rdErr = 1'b1;
        end
        n.preadyQ = 1'b0;
        n.slverrQ = 1'b0;
        if (access && s.preadyQ) begin
            if (!s.slverrQ && pwrite) begin
                if (paddr == OFS_CTRL) begin
                    n.en = pwdata[CTRL_EN];
                    n.dirOut = pwdata[CTRL_DIR];
                    n.trail = pwdata[CTRL_TRAIL];
                    n.latch = pwdata[CTRL_LATCH];
                end else if (paddr == OFS_SETTLE) begin
                    n.settle = pwdata[CNT_W-1:0]; // RL17
                end else if (paddr == OFS_ACKW) begin
                    n.ackW = pwdata[CNT_W-1:0];
                end else if (paddr == OFS_TXDATA) begin
                    bufIf.wValid = 1'b1;
                    bufIf.wData = pwdata[DW-1:0];
                end
            end else if (!s.slverrQ && paddr == OFS_RXDATA) begin
                bufIf.rReady = 1'b1;
            end
        end else if (access && !stall) begin
            n.preadyQ = 1'b1;
            n.slverrQ = rdErr;
            n.prdataQ = (pwrite || rdErr) ? 32'h00000000 : rdVal;
        end
        n.ackLen = s.ackQ ? s.ackLen + (CNT_W+1)'(1) : (CNT_W+1)'(1);
        n.dataAge = (n.dOutQ != s.dOutQ) ? 8'h00 :
            ((s.dataAge == 8'hFF) ? s.dataAge : s.dataAge + 8'h01);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
            s.st <= PHS_IDLE;
            s.oeNQ <= 1'b1;
            s.reqQ <= 1'b0;
            {s.latch, s.trail, s.dirOut, s.en} <= CTRL_RST;
            s.settle <= SETTLE_RST;
            s.ackW <= ACKW_RST;
        end else begin
            s <= n;
        end
    end

    assign prdata = s.prdataQ;
    assign pready = s.preadyQ;
    assign pslverr = s.slverrQ;
    assign ackOut = s.ackQ;
    assign dataOut = s.dOutQ;
    assign dataOeN = s.oeNQ;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic longIn, longOut, teIn, teOut;
    assign longIn = s.en && !s.trail && !s.dirOut;
    assign longOut = s.en && !s.trail && s.dirOut;
    assign teIn = s.en && s.trail && !s.dirOut;
    assign teOut = s.en && s.trail && s.dirOut;

    localparam int RDO_LAST = RDO_MAX_CYC - 1;

    sequence lpReqSeen;
        longIn && s.st == PHS_IDLE && reqIn && !s.reqQ && bufIf.wReady;
    endsequence
    sequence lpAckNext;
        ackOut && s.st == PHS_ACK;
    endsequence

    lp_ack_width_a: assert property ( // RL3
        $fell(ackOut) && $past(!s.trail && s.en)
        |-> $past(s.ackLen) >= (CNT_W+1)'(ACK_MIN_CYC) + $past(s.settle))
        else $error("long pulse ack shorter than least width");
    lp_req_gap_a: assert property ( // RL4
        $fell(ackOut) && $past(longIn) |-> $past(!reqIn, 1)
        && $past(s.lowCnt) >= 8'(REQ_OFF_CYC - 1))
        else $error("ack ended too soon after request went inactive");
    lp_next_word_a: assert property ( // RL5
        longOut && s.latch && s.reqQ && !reqIn && bufIf.rValid
        |=> ##[0:RDO_LAST] dataOut == $past(bufIf.rData))
        else $error("next output word late after request release");
    lp_data_setup_a: assert property ( // RL6
        $rose(ackOut) && longOut && !s.latch |-> s.dataAge >= 8'(DOA_CYC))
        else $error("output word not settled before ack");
    lp_no_early_a: assert property ( // RL7
        longOut && !s.latch && s.st == PHS_IDLE && !s.riseP && !reqIn
        |=> $stable(dataOut))
        else $error("output word changed before any request");
    lp_start_now_a: assert property ( // RL16
        lpReqSeen |=> lpAckNext)
        else $error("long pulse ack start was delayed");
    te_ack_room_a: assert property ( // RL11
        $rose(ackOut) && teIn |-> $past(bufIf.wReady))
        else $error("trailing edge ack issued without room");
    te_ack_width_a: assert property ( // RL12
        $fell(ackOut) && $past(s.trail && s.en)
        |-> $past(s.ackLen) >= {1'b0, $past(s.ackW)} + {1'b0, $past(s.settle)})
        else $error("trailing edge ack shorter than programmed");
    te_word_first_a: assert property ( // RL13
        $rose(ackOut) && teOut |-> s.haveWord && s.dataAge >= 8'(DOA_CYC))
        else $error("ack rose before output word was driven");
    te_req_ends_a: assert property ( // RL15
        $fell(ackOut) && $past(teOut) |-> $past(s.fallP || (s.reqQ && !reqIn)))
        else $error("ack ended without request trailing edge");
endmodule : phs_port

//--- inc/phs_pkg.sv
// Constants, register map and state encoding of the pulse handshake port
package phs_pkg;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    localparam int BUF_DEPTH = 2;
    localparam int CLK_NS = 10;
    localparam int ACK_MIN_NS = 125;
    localparam int REQ_OFF_NS = 150;
    localparam int DOA_NS = 25;
    localparam int RDO_MAX_NS = 50;
    localparam int ACK_MIN_CYC = (ACK_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int REQ_OFF_CYC = (REQ_OFF_NS + CLK_NS - 1) / CLK_NS;
    localparam int DOA_CYC = (DOA_NS + CLK_NS - 1) / CLK_NS;
    localparam int RDO_MAX_CYC = (RDO_MAX_NS / CLK_NS < 1) ? 1 : RDO_MAX_NS / CLK_NS;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SETTLE = 8'h04;
    localparam logic [7:0] OFS_ACKW = 8'h08;
    localparam logic [7:0] OFS_TXDATA = 8'h0C;
    localparam logic [7:0] OFS_RXDATA = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_COUNT = 8'h18;
    localparam int CTRL_EN = 0;
    localparam int CTRL_DIR = 1;
    localparam int CTRL_TRAIL = 2;
    localparam int CTRL_LATCH = 3;
    localparam int ST_RVALID = 0;
    localparam int ST_WREADY = 1;
    localparam int ST_STATE = 2;
    localparam int ST_ACK = 4;
    localparam int ST_REQ = 5;
    localparam int ST_HAVE = 6;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [CNT_W-1:0] SETTLE_RST = 16'h0000;
    localparam logic [CNT_W-1:0] ACKW_RST = CNT_W'(ACK_MIN_CYC);
    typedef enum logic [1:0] {
        PHS_IDLE = 2'b00,
        PHS_SETUP = 2'b01,
        PHS_ACK = 2'b11,
        PHS_WAIT = 2'b10
    } phs_state_e;
endpackage : phs_pkg

//--- inc/phs_stream_if.sv
// Valid/ready carrier between the handshake engine and its word buffer
interface phs_stream_if #(parameter int W = 32);
    logic [W-1:0] wData;
    logic wValid;
    logic wReady;
    logic [W-1:0] rData;
    logic rValid;
    logic rReady;
    modport user (output wData, wValid, rReady, input wReady, rData, rValid);
    modport store (input wData, wValid, rReady, output wReady, rData, rValid);
endinterface : phs_stream_if

//--- rtl/phs_buf2.sv
// Small word buffer with valid and ready on both sides
module phs_buf2 import phs_pkg::*; #(
    parameter int W = DATA_W,
    parameter int DEPTH = BUF_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    phs_stream_if.store port
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] wrPtr;
        logic [PW-1:0] rdPtr;
        logic [CW-1:0] count;
    } phs_buf_s;
    phs_buf_s s, n;
    logic push, pop;

    always_comb begin
        n = s;
        port.wReady = (s.count != CW'(DEPTH));
        port.rValid = (s.count != '0);
        port.rData = s.mem[s.rdPtr];
        push = port.wValid && port.wReady;
        pop = port.rReady && port.rValid;
        if (push) begin
            n.mem[s.wrPtr] = port.wData;
            n.wrPtr = (s.wrPtr == PW'(DEPTH - 1)) ? '0 : s.wrPtr + PW'(1);
        end
        if (pop) begin
            n.rdPtr = (s.rdPtr == PW'(DEPTH - 1)) ? '0 : s.rdPtr + PW'(1);
        end
        if (push && !pop) begin
            n.count = s.count + CW'(1);
        end else if (pop && !push) begin
            n.count = s.count - CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end
endmodule : phs_buf2

//--- dv/phs_periph.sv
// Behavioural peripheral that handshakes with the strobed port
module phs_periph import phs_pkg::*; (
    input wire logic clk,
    input wire logic [3:0] mode,
    input wire logic [7:0] nXfer,
    input wire logic [DATA_W-1:0] base,
    input wire logic start,
    input wire logic ackOut,
    input wire logic [DATA_W-1:0] dataOut,
    output logic reqIn,
    output logic [DATA_W-1:0] dataIn,
    output logic got,
    output logic [DATA_W-1:0] seen,
    output logic done
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic ack_is(input logic v);
        while (ackOut !== v) @(posedge clk);
    endtask : ack_is
    task automatic grab();
        seen <= dataOut;
        got <= 1'b1;
        @(posedge clk);
        got <= 1'b0;
    endtask : grab
    initial begin
        {reqIn, got, done} = 3'b001;
        dataIn = 32'h0;
        seen = 32'h0;
        forever begin
            @(posedge clk);
            if (start) begin
                done <= 1'b0;
                for (int i = 1; i <= nXfer; i++) begin
                    if (!mode[2]) begin
                        reqIn <= 1'b1;
                        dataIn <= base + i;
                        repeat (2) @(posedge clk);
                        // Short hold proves the word was taken at the request edge
                        if (mode[3]) dataIn <= ~dataIn;
                        ack_is(1'b1);
                        if (!mode[3]) dataIn <= ~(base + i);
                        if (mode[1]) grab();
                        repeat (8) @(posedge clk);
                        reqIn <= 1'b0;
                        ack_is(1'b0);
                        repeat (8) @(posedge clk);
                    end else begin
                        ack_is(1'b1);
                        if (mode[1]) grab();
                        else ack_is(1'b0);
                        reqIn <= 1'b1;
                        dataIn <= base + i;
                        repeat (8) @(posedge clk);
                        reqIn <= 1'b0;
                        repeat (2) @(posedge clk);
                        dataIn <= ~(base + i);
                        if (mode[1]) ack_is(1'b0);
                    end
                end
                done <= 1'b1;
            end
        end
    end
endmodule : phs_periph

//--- dv/pulse_handshake_port_bench.sv
// Bench of the pulse handshake port: APB host, peripheral model, timing monitor
module pulse_handshake_port_bench import phs_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, reqIn, ackOut, dataOeN;
    logic start, got, done, err, prevReq;
    logic [3:0] mode;
    logic [7:0] paddr, nXfer;
    logic [31:0] pwdata, prdata, dataIn, dataOut, base, seen, rdv, prevOut;
    logic [31:0] gotQ[$];
    int nErrors = 0, compares = 0, ackHi = 0, reqCyc = 0, doa = 0;
    int lastW, lastRel, lastLead, lastDoa;
    phs_port DUT (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .reqIn, .ackOut, .dataIn, .dataOut, .dataOeN);
    phs_periph peer (.clk, .mode, .nXfer, .base, .start, .ackOut, .dataOut, .reqIn,
        .dataIn, .got, .seen, .done);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Pulse widths and lead times in whole cycles, taken at each acknowledge edge
    always @(posedge clk) begin
        if (got) gotQ.push_back(seen);
        ackHi <= ackOut ? ackHi + 1 : 0;
        reqCyc <= (reqIn !== prevReq) ? 1 : reqCyc + 1;
        doa <= (dataOut !== prevOut) ? 1 : doa + 1;
        prevReq <= reqIn;
        prevOut <= dataOut;
        if (ackOut && ackHi == 0) begin
            lastLead <= reqCyc;
            lastDoa <= doa;
        end
        if (!ackOut && ackHi != 0) begin
            lastW <= ackHi;
            lastRel <= reqCyc;
        end
    end
    task automatic give_verdict();
        $display("errors %0d compares %0d", nErrors, compares);
        if (nErrors == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    task automatic check(input string what, input logic [31:0] act, input logic [31:0] exp);
        compares++;
        if (act !== exp) begin
            nErrors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, act);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
        int t;
        t = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Request stands until pready is seen high at a rising edge, or until 100 rising edges pass
        do @(posedge clk); while (pready !== 1'b1 && ++t < 100);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (t >= 100) nErrors++;
        check("pslverr", 32'(err), 32'(e));
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 1'b0);
        check("read data", rdv, exp);
    endtask : rd
    task automatic setup(input logic [3:0] m);
        apb(1'b1, OFS_CTRL, 32'h0, 1'b0);
        apb(1'b1, OFS_CTRL, 32'(m), 1'b0);
    endtask : setup
    task automatic kick(input logic [3:0] m, input logic [7:0] n, input logic [31:0] b);
        @(posedge clk);
        mode <= m;
        nXfer <= n;
        base <= b;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
    endtask : kick
    task automatic wait_done();
        int t;
        t = 0;
        do @(negedge clk); while (done !== 1'b1 && ++t < 5000);
        check("peer done", 32'(done), 32'h1);
    endtask : wait_done
    task automatic pop(input logic [31:0] exp);
        check("captured word", gotQ.size() ? gotQ.pop_front() : ~exp, exp);
    endtask : pop
    task automatic t_regs();
        rd(OFS_CTRL, 32'h0);
        rd(OFS_ACKW, 32'(ACK_MIN_CYC));
        rd(OFS_STATUS, 32'h2);
        apb(1'b0, 8'h1C, 32'h0, 1'b1);
        apb(1'b0, OFS_RXDATA, 32'h0, 1'b1);
        apb(1'b1, OFS_TXDATA, 32'h0, 1'b1);
    endtask : t_regs
    task automatic t_lp_in();
        apb(1'b1, OFS_SETTLE, 32'h2, 1'b0);
        setup(4'h9);
        kick(4'h9, 8'h2, 32'hA5000000);
        wait_done();
        check("ack width", 32'(lastW >= ACK_MIN_CYC + 2), 32'h1);
        check("ack lead", 32'(lastLead), 32'h1);
        check("release", 32'(lastRel >= REQ_OFF_CYC), 32'h1);
        rd(OFS_RXDATA, 32'hA5000001);
        rd(OFS_RXDATA, 32'hA5000002);
        rd(OFS_COUNT, 32'h2);
    endtask : t_lp_in
    task automatic t_lp_full();
        setup(4'h1);
        kick(4'h1, 8'h3, 32'h5A000000);
        repeat (150) @(negedge clk);
        check("ack when full", 32'(ackOut), 32'h0);
        rd(OFS_RXDATA, 32'h5A000001);
        rd(OFS_RXDATA, 32'h5A000002);
        wait_done();
        rd(OFS_RXDATA, 32'h5A000003);
    endtask : t_lp_full
    task automatic t_out(input logic [3:0] m, input logic [31:0] w1);
        setup(m);
        apb(1'b1, OFS_TXDATA, w1, 1'b0);
        apb(1'b1, OFS_TXDATA, ~w1, 1'b0);
        repeat (4) @(negedge clk);
        check("data enable", 32'(dataOeN), 32'h0);
        check("early word", 32'(dataOut === w1), 32'(m[3] || m[2]));
        kick(m, 8'h2, 32'h0);
        wait_done();
        pop(w1);
        pop(~w1);
        check("data to ack", 32'(lastDoa >= DOA_CYC), 32'h1);
    endtask : t_out
    task automatic t_tr_in();
        apb(1'b1, OFS_ACKW, 32'h4, 1'b0);
        apb(1'b1, OFS_SETTLE, 32'h1, 1'b0);
        kick(4'h5, 8'h2, 32'h3C000000);
        setup(4'h5);
        wait_done();
        check("ack width", 32'(lastW >= 5), 32'h1);
        repeat (40) @(negedge clk);
        check("ack when full", 32'(ackOut), 32'h0);
        rd(OFS_RXDATA, 32'h3C000001);
        rd(OFS_RXDATA, 32'h3C000002);
    endtask : t_tr_in
    initial begin
        #200us;
        nErrors++;
        give_verdict();
    end
    initial begin
        {rst, psel, penable, pwrite, start} = 5'b10000;
        paddr = 8'h00;
        {pwdata, base, mode, nXfer} = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_lp_in();
        t_lp_full();
        t_out(4'h3, 32'h12345671);
        check("ack width", 32'(lastW >= ACK_MIN_CYC + 2), 32'h1);
        t_out(4'hB, 32'h1234567B);
        t_tr_in();
        t_out(4'h7, 32'h12345677);
        check("ack width", 32'(lastW >= 5), 32'h1);
        give_verdict();
    end
endmodule : pulse_handshake_port_bench
